// file: design/brs_consts.vh
/*
 * Constants shared by the bus request scheduler: port size codes, beat
 * counts, address steps, write page field, cycle classes, stall causes.
 * Assumes it is included by bare name from the design file.
 */
`ifndef BRS_CONSTS_VH
`define BRS_CONSTS_VH

// Port size codes carried with every request.
`define BRS_PS_32 2'h0
`define BRS_PS_16 2'h1
`define BRS_PS_8 2'h2

// Beats per transaction.
`define BRS_BEATS_BURST32 5'h04
`define BRS_BEATS_BURST16 5'h08
`define BRS_BEATS_BURST8 5'h10
`define BRS_BEATS_ONE 5'h01
`define BRS_BEATS_TWO 5'h02

// Address step per beat, in bytes.
`define BRS_STEP_32 4'h4
`define BRS_STEP_16 4'h2
`define BRS_STEP_8 4'h1

// A write page is 256 words: the address above bit 9.
`define BRS_PAGE_MSB 31
`define BRS_PAGE_LSB 10

// Core cycle classes.
`define BRS_CLS_RUN 3'h0
`define BRS_CLS_STREAM 3'h1
`define BRS_CLS_WAIT 3'h2
`define BRS_CLS_REFILL 3'h3
`define BRS_CLS_FIXUP 3'h4

// Stall cause bit positions, lowest serviced first.
`define BRS_C_PART 0
`define BRS_C_DATA 1
`define BRS_C_INST 2
`define BRS_C_MDU 3

// Write buffer shape.
`define BRS_WB_DEPTH 8
`define BRS_WB_AW 3
`define BRS_WB_W 68

`endif

// file: design/brs_scheduler.v
/*
 * Bus request scheduler: write buffer FIFO, bus interface arbiter and
 * transaction sequencer, and the core stall and cycle class engine.
 * Assumes the core holds each request level until the fixup cycle that
 * ends its stall, and that bus acknowledge and DMA request come from
 * outside the clock domain.
 */
`timescale 1ns/1ps
`default_nettype none
`include "brs_consts.vh"

// ****************************************
// Write buffer FIFO
// ****************************************
module brs_wbuf #(
	parameter W = 68,
	parameter DEPTH = 8,
	parameter AW = 3
) (
	input  wire         mclk_i,
	input  wire         reset_i,
	input  wire         in_valid_i,
	output wire         in_ready_o,
	input  wire [W-1:0] in_data_i,
	output wire         out_valid_o,
	input  wire         out_ready_i,
	output wire [W-1:0] out_data_o
);
	localparam integer FULL_I = DEPTH;
	localparam integer LAST_I = DEPTH - 1;
	localparam [AW:0] FULL = FULL_I[AW:0];
	localparam [AW-1:0] LAST = LAST_I[AW-1:0];
	reg  [W-1:0]  mem [0:DEPTH-1];
	reg  [AW-1:0] wp;
	reg  [AW-1:0] rp;
	reg  [AW:0]   cnt;
	wire          push;
	wire          pop;

	assign in_ready_o = (cnt != FULL);
	assign out_valid_o = (cnt != {(AW+1){1'b0}});
	assign out_data_o = mem[rp];
	assign push = in_valid_i & in_ready_o;
	assign pop = out_valid_o & out_ready_i;

	always @(posedge mclk_i) begin
		if (push) begin
			mem[wp] <= in_data_i;
		end
	end

	always @(posedge mclk_i) begin
		if (reset_i) begin
			wp <= {AW{1'b0}};
			rp <= {AW{1'b0}};
			cnt <= {(AW+1){1'b0}};
		end else begin
			if (push) begin
				wp <= (wp == LAST) ? {AW{1'b0}} : wp + 1'b1;
			end
			if (pop) begin
				rp <= (rp == LAST) ? {AW{1'b0}} : rp + 1'b1;
			end
			if (push & ~pop) begin
				cnt <= cnt + 1'b1;
			end else if (pop & ~push) begin
				cnt <= cnt - 1'b1;
			end
		end
	end
endmodule

// ****************************************
// Scheduler top
// ****************************************
module brs_scheduler (
	input  wire        mclk_i,
	input  wire        reset_i,
	input  wire        core_dread_i,
	input  wire [31:0] core_dread_addr_i,
	input  wire        core_dread_cached_i,
	input  wire [1:0]  core_dread_size_i,
	input  wire [1:0]  core_dread_ps_i,
	input  wire        core_iread_i,
	input  wire [31:0] core_iread_addr_i,
	input  wire        core_iread_cached_i,
	input  wire [1:0]  core_iread_ps_i,
	input  wire        core_store_i,
	input  wire [31:0] core_store_addr_i,
	input  wire [31:0] core_store_data_i,
	input  wire [1:0]  core_store_size_i,
	input  wire [1:0]  core_store_ps_i,
	input  wire        core_store_partial_i,
	input  wire        core_muldiv_read_i,
	input  wire        muldiv_busy_i,
	input  wire        data_block_refill_enable_i,
	input  wire        core_stream_en_i,
	output wire        core_stall_o,
	output reg  [2:0]  cycle_class_o,
	output reg  [31:0] rd_data_o,
	output reg         rd_valid_o,
	output reg         icache_fill_o,
	output reg         dcache_fill_o,
	input  wire        bus_ack_n_i,
	input  wire [31:0] bus_rdata_i,
	input  wire        dma_req_n_i,
	output wire        bus_ale_o,
	output wire        bus_rd_n_o,
	output wire        bus_wr_n_o,
	output wire        bus_burst_n_o,
	output wire        write_page_hit_indicator_n_o,
	output wire [31:0] bus_addr_o,
	output wire [31:0] bus_wdata_o,
	output wire        bus_drive_o,
	output wire        dma_grant_n_o
);
	localparam [1:0] E_RUN = 2'h0;
	localparam [1:0] E_STALL = 2'h1;
	localparam [1:0] E_FIX = 2'h2;
	localparam [2:0] B_IDLE = 3'h0;
	localparam [2:0] B_ADDR = 3'h1;
	localparam [2:0] B_RD = 3'h2;
	localparam [2:0] B_WR = 3'h3;
	localparam [2:0] B_DMA = 3'h4;

	// Beats in one transaction; a single transfer splits into beats on narrow ports only.
	function [4:0] brs_beats;
		input [1:0] ps;
		input [1:0] nb;
		input       burst;
		begin
			if (burst) begin
				case (ps)
				`BRS_PS_32: brs_beats = `BRS_BEATS_BURST32;
				`BRS_PS_16: brs_beats = `BRS_BEATS_BURST16;
				default: brs_beats = `BRS_BEATS_BURST8;
				endcase
			end else begin
				case (ps)
				`BRS_PS_32: brs_beats = `BRS_BEATS_ONE;
				`BRS_PS_16: brs_beats = nb[1] ? `BRS_BEATS_TWO : `BRS_BEATS_ONE;
				default: brs_beats = {3'h0, nb} + `BRS_BEATS_ONE;
				endcase
			end
		end
	endfunction

	function [3:0] brs_step;
		input [1:0] ps;
		begin
			case (ps)
			`BRS_PS_32: brs_step = `BRS_STEP_32;
			`BRS_PS_16: brs_step = `BRS_STEP_16;
			default: brs_step = `BRS_STEP_8;
			endcase
		end
	endfunction

	// ****************************************
	// Input synchronisers
	// ****************************************
	reg ack_m;
	reg ack_n_s;
	reg ack_n_d;
	reg dma_m;
	reg dma_n_s;
	wire ack_hit;
	wire dma_want;

	always @(posedge mclk_i) begin
		if (reset_i) begin
			ack_m <= 1'b1;
			ack_n_s <= 1'b1;
			ack_n_d <= 1'b1;
			dma_m <= 1'b1;
			dma_n_s <= 1'b1;
		end else begin
			ack_m <= bus_ack_n_i;
			ack_n_s <= ack_m;
			ack_n_d <= ack_n_s;
			dma_m <= dma_req_n_i;
			dma_n_s <= dma_m;
		end
	end

	// Each beat is one falling edge of acknowledge, so a held level
	// cannot retire two beats.
	assign ack_hit = ~ack_n_s & ack_n_d;
	assign dma_want = ~dma_n_s;

	// ****************************************
	// Write buffer
	// ****************************************
	reg  [1:0]  eng;
	reg  [3:0]  pend;
	reg         got_d;
	reg         got_i;
	reg  [2:0]  bst;
	wire [3:0]  cause;
	wire        wb_in_ready;
	wire        wb_in_valid;
	wire        wb_out_valid;
	wire        wb_out_ready;
	wire [67:0] wb_out;

	// Stores only ever enter the write buffer, never an instruction fill.
	assign wb_in_valid = core_store_i &
		(((eng == E_RUN) & ~(|cause)) | (eng == E_FIX));

	brs_wbuf #(
		.W(`BRS_WB_W),
		.DEPTH(`BRS_WB_DEPTH),
		.AW(`BRS_WB_AW)
	) u_wbuf (
		.mclk_i      (mclk_i),
		.reset_i     (reset_i),
		.in_valid_i  (wb_in_valid),
		.in_ready_o  (wb_in_ready),
		.in_data_i   ({core_store_ps_i, core_store_size_i,
			core_store_addr_i, core_store_data_i}),
		.out_valid_o (wb_out_valid),
		.out_ready_i (wb_out_ready),
		.out_data_o  (wb_out)
	);

	// ****************************************
	// Stall engine
	// ****************************************
	wire       rd_done;
	wire       d_clear;
	wire       need_d;
	wire       need_i;
	reg  [3:0] next_pend;
	reg        t_inst;

	// No translation buffer exists, so no cause for a translation stall.
	assign cause = {core_muldiv_read_i & muldiv_busy_i,
		core_iread_i,
		core_dread_i | (core_store_i & ~wb_in_ready),
		core_store_i & core_store_partial_i};

	assign d_clear = (~core_dread_i | got_d) &
		(~core_store_i | wb_in_ready);
	assign need_d = (eng == E_STALL) & pend[`BRS_C_DATA] &
		core_dread_i & ~got_d;
	// Instruction miss read waits until data causes are cleared.
	assign need_i = (eng == E_STALL) & pend[`BRS_C_INST] &
		~pend[`BRS_C_DATA] & ~pend[`BRS_C_PART] & ~got_i;

	// One cause is retired per cycle, lowest bit first.
	always @* begin
		next_pend = pend;
		if (pend[`BRS_C_PART]) begin
			next_pend[`BRS_C_PART] = 1'b0;
		end else if (pend[`BRS_C_DATA]) begin
			if (d_clear) begin
				next_pend[`BRS_C_DATA] = 1'b0;
			end
		end else if (pend[`BRS_C_INST]) begin
			if (got_i) begin
				next_pend[`BRS_C_INST] = 1'b0;
			end
		end else if (~muldiv_busy_i) begin
			next_pend[`BRS_C_MDU] = 1'b0;
		end
	end

	always @(posedge mclk_i) begin
		if (reset_i) begin
			eng <= E_RUN;
			pend <= 4'h0;
			got_d <= 1'b0;
			got_i <= 1'b0;
		end else begin
			case (eng)
			E_RUN: begin
				if (|cause) begin
					eng <= E_STALL;
					pend <= cause;
				end
			end
			E_STALL: begin
				pend <= next_pend;
				if (rd_done & t_inst) begin
					got_i <= 1'b1;
				end
				if (rd_done & ~t_inst) begin
					got_d <= 1'b1;
				end
				if (next_pend == 4'h0) begin
					eng <= E_FIX;
				end
			end
			E_FIX: begin
				eng <= E_RUN;
				got_d <= 1'b0;
				got_i <= 1'b0;
			end
			default: begin
				eng <= E_RUN;
			end
			endcase
		end
	end

	// ****************************************
	// Cycle classification
	// ****************************************
	always @* begin
		case (eng)
		E_RUN: cycle_class_o = `BRS_CLS_RUN;
		E_FIX: cycle_class_o = `BRS_CLS_FIXUP;
		E_STALL: begin
			if (icache_fill_o & core_stream_en_i) begin
				cycle_class_o = `BRS_CLS_STREAM;
			end else if (icache_fill_o | dcache_fill_o) begin
				cycle_class_o = `BRS_CLS_REFILL;
			end else begin
				cycle_class_o = `BRS_CLS_WAIT;
			end
		end
		default: cycle_class_o = `BRS_CLS_RUN;
		endcase
	end

	// A streaming cycle lets the core advance while the refill goes on.
	assign core_stall_o = (eng != E_RUN) &
		(cycle_class_o != `BRS_CLS_STREAM);

	// ****************************************
	// Bus arbiter and sequencer
	// ****************************************
	reg         t_wr;
	reg         t_cached;
	reg         t_burst;
	reg  [1:0]  t_ps;
	reg  [31:0] t_base;
	reg  [31:0] t_wdata;
	reg  [3:0]  low;
	reg  [4:0]  beats;
	reg         page_hit;
	reg         last_wr;
	reg  [21:0] last_page;
	wire        go_dma;
	wire        go_i;
	wire        go_w;
	wire        go_d;
	wire        i_burst;
	wire        d_burst;
	wire [31:0] w_addr;

	assign go_dma = (bst == B_IDLE) & dma_want;
	// An uncached fetch waits for the write buffer to drain first.
	assign go_i = (bst == B_IDLE) & ~dma_want & need_i &
		(core_iread_cached_i | ~wb_out_valid);
	assign go_w = (bst == B_IDLE) & ~dma_want & ~go_i &
		wb_out_valid;
	// Data reads wait behind every buffered write, so a read of a
	// pending address always sees the newest value.
	assign go_d = (bst == B_IDLE) & ~dma_want & ~go_i &
		~wb_out_valid & need_d;
	assign wb_out_ready = go_w;
	assign i_burst = core_iread_cached_i;
	assign d_burst = core_dread_cached_i &
		data_block_refill_enable_i;
	assign w_addr = wb_out[63:32];
	assign rd_done = (bst == B_RD) & ack_hit &
		(beats == `BRS_BEATS_ONE);

	always @(posedge mclk_i) begin
		if (reset_i) begin
			bst <= B_IDLE;
			t_wr <= 1'b0;
			t_inst <= 1'b0;
			t_cached <= 1'b0;
			t_burst <= 1'b0;
			t_ps <= `BRS_PS_32;
			t_base <= 32'h00000000;
			t_wdata <= 32'h00000000;
			low <= 4'h0;
			beats <= 5'h00;
			page_hit <= 1'b0;
			last_wr <= 1'b0;
			last_page <= 22'h000000;
			rd_data_o <= 32'h00000000;
			rd_valid_o <= 1'b0;
			icache_fill_o <= 1'b0;
			dcache_fill_o <= 1'b0;
		end else begin
			rd_valid_o <= 1'b0;
			icache_fill_o <= 1'b0;
			dcache_fill_o <= 1'b0;
			case (bst)
			B_IDLE: begin
				if (go_dma) begin
					bst <= B_DMA;
					last_wr <= 1'b0;
				end else if (go_i) begin
					bst <= B_ADDR;
					t_wr <= 1'b0;
					t_inst <= 1'b1;
					t_cached <= core_iread_cached_i;
					t_burst <= i_burst;
					t_ps <= core_iread_ps_i;
					t_base <= core_iread_addr_i;
					low <= i_burst ? 4'h0 : core_iread_addr_i[3:0];
					beats <= brs_beats(core_iread_ps_i, 2'h3, i_burst);
					last_wr <= 1'b0;
				end else if (go_w) begin
					bst <= B_ADDR;
					t_wr <= 1'b1;
					t_inst <= 1'b0;
					t_cached <= 1'b0;
					t_burst <= 1'b0;
					t_ps <= wb_out[67:66];
					t_base <= w_addr;
					t_wdata <= wb_out[31:0];
					low <= w_addr[3:0];
					beats <= brs_beats(wb_out[67:66], wb_out[65:64], 1'b0);
					page_hit <= last_wr & (w_addr[`BRS_PAGE_MSB:
						`BRS_PAGE_LSB] == last_page);
				end else if (go_d) begin
					bst <= B_ADDR;
					t_wr <= 1'b0;
					t_inst <= 1'b0;
					t_cached <= core_dread_cached_i;
					t_burst <= d_burst;
					t_ps <= core_dread_ps_i;
					t_base <= core_dread_addr_i;
					low <= d_burst ? 4'h0 : core_dread_addr_i[3:0];
					beats <= brs_beats(core_dread_ps_i,
						core_dread_size_i, d_burst);
					last_wr <= 1'b0;
				end
			end
			B_ADDR: begin
				// Address phase lasts one cycle; the read or write strobe
				// state follows on the next edge.
				bst <= t_wr ? B_WR : B_RD;
			end
			B_RD: begin
				if (ack_hit) begin
					rd_data_o <= bus_rdata_i;
					rd_valid_o <= 1'b1;
					icache_fill_o <= t_inst & t_cached;
					dcache_fill_o <= ~t_inst & t_cached;
					beats <= beats - 1'b1;
					low <= low + brs_step(t_ps);
					if (beats == `BRS_BEATS_ONE) begin
						bst <= B_IDLE;
					end
				end
			end
			B_WR: begin
				if (ack_hit) begin
					beats <= beats - 1'b1;
					low <= low + brs_step(t_ps);
					if (beats == `BRS_BEATS_ONE) begin
						bst <= B_IDLE;
						last_wr <= 1'b1;
						last_page <= t_base[`BRS_PAGE_MSB:`BRS_PAGE_LSB];
					end
				end
			end
			B_DMA: begin
				if (~dma_want) begin
					bst <= B_IDLE;
				end
			end
			default: begin
				bst <= B_IDLE;
			end
			endcase
		end
	end

	// ****************************************
	// Bus outputs
	// ****************************************
	// Strobes come only from an active transaction state.
	assign bus_ale_o = (bst == B_ADDR);
	assign bus_rd_n_o = ~(bst == B_RD);
	assign bus_wr_n_o = ~(bst == B_WR);
	assign bus_burst_n_o = ~(t_burst & ~t_wr &
		((bst == B_ADDR) | (bst == B_RD)));
	assign write_page_hit_indicator_n_o = ~(page_hit & t_wr &
		((bst == B_ADDR) | (bst == B_WR)));
	assign bus_addr_o = {t_base[31:4], low};
	assign bus_wdata_o = t_wdata;
	// Releasing the drive hands the whole bus to the DMA agent.
	assign bus_drive_o = (bst != B_DMA);
	assign dma_grant_n_o = ~(bst == B_DMA);
endmodule
`default_nettype wire

// file: tb/brs_mem_agent.sv
/*
 * Memory, I/O and DMA agent on the far side of the scheduler's bus.
 * Assumes strobes are sampled at rising edges and the latency input is
 * held steady during a transaction.
 */
`timescale 1ns/1ps
`default_nettype none

// ********
// Agent
// ********
module brs_mem_agent (
	input  wire logic        mclk_i,
	input  wire logic        rd_n_i,
	input  wire logic        wr_n_i,
	input  wire logic [31:0] addr_i,
	input  wire logic [31:0] wdata_i,
	input  wire logic        dma_want_i,
	input  wire logic [2:0]  lat_i,
	output logic             ack_n_o,
	output logic [31:0]      rdata_o,
	output logic             dma_req_n_o
);
	logic [31:0] mem [logic [31:0]];

	assign dma_req_n_o = !dma_want_i;

	initial begin
		ack_n_o = 1'b1;
		rdata_o = 32'h0;
		forever begin
			@(posedge mclk_i);
			if (!rd_n_i || !wr_n_i) begin
				repeat (lat_i) @(posedge mclk_i);
				if (!wr_n_i)
					mem[addr_i] = wdata_i;
				rdata_o <= mem.exists(addr_i) ? mem[addr_i] : ~addr_i;
				ack_n_o <= 1'b0;
				repeat (3) @(posedge mclk_i);
				ack_n_o <= 1'b1;
				repeat (2) @(posedge mclk_i);
			end else begin
				// An undriven data bus keeps changing so stale data is caught.
				rdata_o <= ~rdata_o;
			end
		end
	end
endmodule
`default_nettype wire

// file: tb/brs_scheduler_bench.sv
/*
 * Self-checking bench for the bus request scheduler.
 * Assumes the checker is bound by its own file and the agent answers.
 */
`timescale 1ns/1ps
`default_nettype none
`include "brs_consts.vh"

module brs_scheduler_bench;
	logic        mclk, rst, dr, dc, ir, ic, st, sp, mr, mb, dbe, se, dw;
	logic [1:0]  dsz, dps, ips, ssz, sps;
	logic [31:0] da, ia, sa, sd, last;
	logic [2:0]  lat;
	logic [7:0]  ord;
	logic        fb, ackp, alp;
	wire         stall, rdv, ifl, dfl, ale, rdn, wrn, brn, wph, drv, gnt;
	wire         ack, dmq;
	wire  [2:0]  cls;
	wire  [31:0] rdd, addr, wd, rdt;
	int          err_total, total_checks, beats, fills, alc, phs, wbeats;

	brs_scheduler dut_u (.mclk_i(mclk), .reset_i(rst),
		.core_dread_i(dr), .core_dread_addr_i(da),
		.core_dread_cached_i(dc), .core_dread_size_i(dsz),
		.core_dread_ps_i(dps), .core_iread_i(ir), .core_iread_addr_i(ia),
		.core_iread_cached_i(ic), .core_iread_ps_i(ips),
		.core_store_i(st), .core_store_addr_i(sa), .core_store_data_i(sd),
		.core_store_size_i(ssz), .core_store_ps_i(sps),
		.core_store_partial_i(sp), .core_muldiv_read_i(mr),
		.muldiv_busy_i(mb), .data_block_refill_enable_i(dbe),
		.core_stream_en_i(se), .core_stall_o(stall), .cycle_class_o(cls),
		.rd_data_o(rdd), .rd_valid_o(rdv), .icache_fill_o(ifl),
		.dcache_fill_o(dfl), .bus_ack_n_i(ack), .bus_rdata_i(rdt),
		.dma_req_n_i(dmq), .bus_ale_o(ale), .bus_rd_n_o(rdn),
		.bus_wr_n_o(wrn), .bus_burst_n_o(brn),
		.write_page_hit_indicator_n_o(wph), .bus_addr_o(addr),
		.bus_wdata_o(wd), .bus_drive_o(drv), .dma_grant_n_o(gnt));
	brs_mem_agent mem_u (.mclk_i(mclk), .rd_n_i(rdn), .wr_n_i(wrn),
		.addr_i(addr), .wdata_i(wd), .dma_want_i(dw), .lat_i(lat),
		.ack_n_o(ack), .rdata_o(rdt), .dma_req_n_o(dmq));

	always #2 mclk = ~mclk;

	// ********
	// Observers
	// ********
	always @(posedge mclk) begin
		ackp <= ack;
		alp <= ale;
		if (rdv === 1'b1) begin
			beats++;
			last = rdd;
		end
		if ((ifl | dfl) === 1'b1)
			fills++;
		if (wph === 1'b0)
			phs++;
		if (ack === 1'b0 && ackp === 1'b1 && wrn === 1'b0)
			wbeats++;
		if (ale === 1'b1) begin
			if (alc == 0)
				fb <= brn;
			alc++;
		end
		if (alp === 1'b1)
			ord <= {ord[6:0], wrn === 1'b0};
	end

	// ********
	// Helpers
	// ********
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			err_total++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic conclude;
		$display("Checks %0d, errors %0d", total_checks, err_total);
		if (err_total == 0 && total_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	task automatic clr;
		beats = 0;
		fills = 0;
		alc = 0;
		phs = 0;
		wbeats = 0;
		ord = 8'h00;
	endtask

	// Requests are held until a fixup with all wanted beats, then dropped.
	task automatic fix(input int need);
		int n;
		n = 0;
		do begin
			@(posedge mclk);
			n++;
		end while (!(cls === `BRS_CLS_FIXUP && beats >= need) && n < 3000);
		chk(n < 3000, 1'b1);
		dr <= 1'b0;
		ir <= 1'b0;
		mr <= 1'b0;
		st <= 1'b0;
		sp <= 1'b0;
		repeat (2) @(posedge mclk);
	endtask

	task automatic store(input logic [31:0] a, input logic [1:0] z,
		input logic [1:0] p);
		st <= 1'b1;
		sa <= a;
		sd <= a ^ 32'h5A5A_0000;
		ssz <= z;
		sps <= p;
	endtask

	task automatic waitw(input int n);
		int k;
		k = 0;
		while (wbeats < n && k < 800) begin
			@(posedge mclk);
			k++;
		end
		chk(wbeats, n);
		repeat (4) @(posedge mclk);
	endtask

	// ********
	// Scenarios
	// ********
	task automatic t_reads;
		logic [15:0] tv [12];
		logic [15:0] e;
		tv = '{16'h0301, 16'h0702, 16'h0501, 16'h0902, 16'h0A03, 16'h0B04,
			16'h7304, 16'h4301, 16'hD304, 16'hD708, 16'hDB10, 16'h8301};
		foreach (tv[i]) begin
			e = tv[i];
			clr;
			lat <= (i % 2) ? 3'h3 : 3'h0;
			dbe <= e[13];
			se <= e[15];
			ir <= e[15];
			ic <= e[14];
			ia <= 32'h400;
			ips <= e[11:10];
			dr <= !e[15];
			dc <= e[14];
			da <= 32'h1000;
			dsz <= e[9:8];
			dps <= e[11:10];
			fix(e[7:0]);
			chk(beats, e[7:0]);
			chk(fills, e[14] ? e[7:0] : 8'h00);
			chk(fb, !e[12]);
		end
	endtask

	task automatic t_full;
		int k;
		clr;
		lat <= 3'h7;
		store(32'h2000, 2'h3, 2'h0);
		k = 0;
		while (stall !== 1'b1 && k < 100) begin
			@(posedge mclk);
			k++;
		end
		chk(stall, 1'b1);
		fix(0);
		chk(alc > 0, 1'b1);
		chk(phs > 0, 1'b1);
		// Let the full buffer drain so later one-cycle stores are taken.
		repeat (160) @(posedge mclk);
	endtask

	task automatic t_wr_rd;
		clr;
		lat <= 3'h2;
		store(32'h200, 2'h3, 2'h0);
		@(posedge mclk);
		st <= 1'b0;
		dr <= 1'b1;
		dc <= 1'b0;
		da <= 32'h200;
		dsz <= 2'h3;
		dps <= 2'h0;
		fix(1);
		chk(last, 32'h5A5A_0200);
		chk(ord[1:0], 2'h2);
		clr;
		store(32'h204, 2'h3, 2'h0);
		@(posedge mclk);
		st <= 1'b0;
		ir <= 1'b1;
		ic <= 1'b0;
		ips <= 2'h0;
		fix(1);
		chk(ord[1:0], 2'h2);
	endtask

	task automatic t_pair;
		clr;
		lat <= 3'h0;
		dr <= 1'b1;
		dc <= 1'b0;
		dps <= 2'h0;
		dsz <= 2'h3;
		ir <= 1'b1;
		ic <= 1'b1;
		fix(5);
		chk(fb, 1'b1);
		chk(beats, 5);
	endtask

	task automatic t_writes;
		clr;
		store(32'h300, 2'h3, 2'h0);
		@(posedge mclk);
		sa <= 32'h304;
		@(posedge mclk);
		st <= 1'b0;
		waitw(2);
		chk(phs > 0, 1'b1);
		clr;
		store(32'h9000, 2'h3, 2'h0);
		@(posedge mclk);
		st <= 1'b0;
		waitw(1);
		chk(phs, 0);
		clr;
		store(32'h3000, 2'h3, 2'h2);
		@(posedge mclk);
		st <= 1'b0;
		waitw(4);
		clr;
		store(32'h3010, 2'h3, 2'h1);
		@(posedge mclk);
		st <= 1'b0;
		waitw(2);
	endtask

	task automatic t_muldiv;
		mb <= 1'b1;
		mr <= 1'b1;
		repeat (6) @(posedge mclk);
		chk(stall, 1'b1);
		mb <= 1'b0;
		fix(0);
		chk(stall, 1'b0);
		clr;
		store(32'h3100, 2'h1, 2'h0);
		sp <= 1'b1;
		fix(0);
		waitw(1);
	endtask

	task automatic t_dma;
		int k;
		clr;
		dw <= 1'b1;
		k = 0;
		while (gnt !== 1'b0 && k < 20) begin
			@(posedge mclk);
			k++;
		end
		chk(drv, 1'b0);
		dr <= 1'b1;
		da <= 32'h40;
		repeat (20) @(posedge mclk);
		chk(alc, 0);
		dw <= 1'b0;
		fix(1);
		chk({gnt, drv}, 2'h3);
	endtask

	initial begin
		mclk = 1'b0;
		rst = 1'b1;
		{dr, dc, ir, ic, st, sp, mr, mb, dbe, se, dw} = 11'h000;
		{dsz, dps, ips, ssz, sps} = 10'h000;
		{da, ia, sa, sd} = 128'h0;
		lat = 3'h0;
		err_total = 0;
		total_checks = 0;
		clr;
		repeat (10) @(posedge mclk);
		rst <= 1'b0;
		repeat (3) @(posedge mclk);
		chk({rdn, wrn, brn, wph, gnt, drv, ale, stall}, 8'hFC);
		chk(cls, `BRS_CLS_RUN);
		t_reads;
		t_full;
		t_wr_rd;
		t_pair;
		t_writes;
		t_muldiv;
		t_dma;
		conclude;
	end

	initial begin
		#200000;
		err_total++;
		conclude;
	end
endmodule
`default_nettype wire

// file: tb/brs_scheduler_monitor.sv
/*
 * Checker for the bus request scheduler, watching its top ports only.
 * Assumes the design constants header is on the include path.
 */
`timescale 1ns/1ps
`default_nettype none
`include "brs_consts.vh"

// ********
// Checker
// ********
module brs_scheduler_monitor (
	input wire logic       mclk_i,
	input wire logic       reset_i,
	input wire logic       core_stall_o,
	input wire logic [2:0] cycle_class_o,
	input wire logic       rd_valid_o,
	input wire logic       icache_fill_o,
	input wire logic       dcache_fill_o,
	input wire logic       bus_ale_o,
	input wire logic       bus_rd_n_o,
	input wire logic       bus_wr_n_o,
	input wire logic       bus_burst_n_o,
	input wire logic       write_page_hit_indicator_n_o,
	input wire logic       bus_drive_o,
	input wire logic       dma_grant_n_o
);
	default clocking cb @(posedge mclk_i);
	endclocking
	default disable iff (reset_i);

	chk_dma_quiet: assert property (
		!dma_grant_n_o |-> bus_rd_n_o && bus_wr_n_o && !bus_drive_o)
		else $error("bus active while granted");
	chk_ale_strobe: assert property (
		bus_ale_o |=> !bus_ale_o && (!bus_rd_n_o || !bus_wr_n_o))
		else $error("address cycle not followed by a strobe");
	chk_burst_read: assert property (
		!bus_burst_n_o |-> bus_wr_n_o)
		else $error("burst marker on a write");
	chk_page_write: assert property (
		!write_page_hit_indicator_n_o |-> bus_rd_n_o)
		else $error("page hit marker on a read");
	chk_class_legal: assert property (
		cycle_class_o <= `BRS_CLS_FIXUP)
		else $error("unknown cycle class");
	// A streaming cycle drops the stall without ending it.
	chk_stall_fixup: assert property (
		$fell(core_stall_o) && cycle_class_o == `BRS_CLS_RUN
		|-> $past(cycle_class_o) == `BRS_CLS_FIXUP)
		else $error("stall ended without a fixup cycle");
	chk_fill_beat: assert property (
		icache_fill_o || dcache_fill_o |-> rd_valid_o)
		else $error("cache fill without a read beat");
	chk_one_cache: assert property (
		!(icache_fill_o && dcache_fill_o))
		else $error("both caches filled at once");
	chk_txn_gap: assert property (
		$rose(bus_rd_n_o) || $rose(bus_wr_n_o) |-> !bus_ale_o)
		else $error("no idle cycle between transactions");
	chk_stream_run: assert property (
		cycle_class_o == `BRS_CLS_STREAM |-> !core_stall_o)
		else $error("streaming cycle marked as stall");
	chk_stall_class: assert property (
		cycle_class_o >= `BRS_CLS_WAIT |-> core_stall_o)
		else $error("stall class without stall");

	cover property (bus_ale_o && !bus_burst_n_o);
	cover property (!write_page_hit_indicator_n_o);
	cover property (!dma_grant_n_o);
	cover property (cycle_class_o == `BRS_CLS_STREAM);
endmodule

bind brs_scheduler brs_scheduler_monitor mon_u (
	.mclk_i(mclk_i),
	.reset_i(reset_i),
	.core_stall_o(core_stall_o),
	.cycle_class_o(cycle_class_o),
	.rd_valid_o(rd_valid_o),
	.icache_fill_o(icache_fill_o),
	.dcache_fill_o(dcache_fill_o),
	.bus_ale_o(bus_ale_o),
	.bus_rd_n_o(bus_rd_n_o),
	.bus_wr_n_o(bus_wr_n_o),
	.bus_burst_n_o(bus_burst_n_o),
	.write_page_hit_indicator_n_o(write_page_hit_indicator_n_o),
	.bus_drive_o(bus_drive_o),
	.dma_grant_n_o(dma_grant_n_o)
);
`default_nettype wire
